//--- ehs_hdr_sequencer.sv
// hdr exposure sequencer: interleaved rows and piecewise linear clipping
// Notes on behaviour
// - all hdr modes work internal and external
// - interleave enable at 41 bit 1
// - even rows use 42..44 when interleaved
// - odd rows use 56..58 when interleaved
// - span = 129 clocks times (0.43*ovh+field)
// - pin a times even, pin b odd when interleaved
// - sensor bit 0 groups rows by Bayer
// - clip level changes twice, three slopes max
// - slope count at 54 bits 1:0
// - first knee span from 48..50
// - second knee span from 51..53
// - clip three: enable bit 6, level 5:0
// - clip two: enable bit 6, level 5:0
// - 42..44 is total span holding knees
// - clip levels place knees, spans set slopes
// - 41 bit 0 picks pin or register timing
// - overhead length taken from register 73
// - external span: pin a rise to request rise, then an overhead tail
`timescale 1ns/1ps
`include "ehs_regs.svh"
module ehs_hdr_sequencer
    import ehs_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire ehs_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic exposure_pin_a_i,
    input wire logic exposure_pin_b_i,
    input wire logic frame_req_i,
    output logic expose_even_o,
    output logic expose_odd_o,
    output logic clip_active_o,
    output logic [5:0] clip_level_o,
    output logic row_pair_group_o,
    output logic busy_o,
    output logic exposure_done_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // pin synchronisers, then one more stage for edges
    logic [2:0] pins, s1_q, s2_q, prev_q;
    assign pins = {frame_req_i, exposure_pin_b_i, exposure_pin_a_i};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end
                else if (ce_i)
                begin
                    s1_q[gi] <= pins[gi];
                    s2_q[gi] <= s1_q[gi];
                    prev_q[gi] <= s2_q[gi];
                end
            end
        end
    endgenerate

    logic a_rise, b_rise, fr_rise;
    assign a_rise = s2_q[0] & ~prev_q[0];
    assign b_rise = s2_q[1] & ~prev_q[1];
    assign fr_rise = s2_q[2] & ~prev_q[2];

    // configuration registers
    ehs_cfg_t cfg_q, cfg_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb
    begin
        cfg_d = cfg_q;
        rdata_d = rdata_q;
        if (reg_req_i.wr)
        begin
            unique case (reg_req_i.addr)
                `EHS_A_SENSOR: cfg_d.mono = reg_req_i.wdata[`EHS_B_MONO];
                `EHS_A_EXPCTL:
                begin
                    cfg_d.ext = reg_req_i.wdata[`EHS_B_EXT];
                    cfg_d.ilv = reg_req_i.wdata[`EHS_B_ILV];
                end
                `EHS_A_EVEN0: cfg_d.even_len[7:0] = reg_req_i.wdata;
                `EHS_A_EVEN1: cfg_d.even_len[15:8] = reg_req_i.wdata;
                `EHS_A_EVEN2: cfg_d.even_len[23:16] = reg_req_i.wdata;
                `EHS_A_KNEE1_0: cfg_d.knee1_len[7:0] = reg_req_i.wdata;
                `EHS_A_KNEE1_1: cfg_d.knee1_len[15:8] = reg_req_i.wdata;
                `EHS_A_KNEE1_2: cfg_d.knee1_len[23:16] = reg_req_i.wdata;
                `EHS_A_KNEE2_0: cfg_d.knee2_len[7:0] = reg_req_i.wdata;
                `EHS_A_KNEE2_1: cfg_d.knee2_len[15:8] = reg_req_i.wdata;
                `EHS_A_KNEE2_2: cfg_d.knee2_len[23:16] = reg_req_i.wdata;
                `EHS_A_SLOPES: cfg_d.slopes = reg_req_i.wdata[1:0];
                `EHS_A_ODD0: cfg_d.odd_len[7:0] = reg_req_i.wdata;
                `EHS_A_ODD1: cfg_d.odd_len[15:8] = reg_req_i.wdata;
                `EHS_A_ODD2: cfg_d.odd_len[23:16] = reg_req_i.wdata;
                `EHS_A_OVH: cfg_d.ovh = reg_req_i.wdata;
                `EHS_A_CLIP2: cfg_d.clip2 = reg_req_i.wdata[6:0];
                `EHS_A_CLIP3: cfg_d.clip3 = reg_req_i.wdata[6:0];
                default: ;
            endcase
        end
        if (reg_req_i.rd)
        begin
            unique case (reg_req_i.addr)
                `EHS_A_SENSOR: rdata_d = {7'h00, cfg_q.mono};
                `EHS_A_EXPCTL: rdata_d = {6'h00, cfg_q.ilv, cfg_q.ext};
                `EHS_A_EVEN0: rdata_d = cfg_q.even_len[7:0];
                `EHS_A_EVEN1: rdata_d = cfg_q.even_len[15:8];
                `EHS_A_EVEN2: rdata_d = cfg_q.even_len[23:16];
                `EHS_A_KNEE1_0: rdata_d = cfg_q.knee1_len[7:0];
                `EHS_A_KNEE1_1: rdata_d = cfg_q.knee1_len[15:8];
                `EHS_A_KNEE1_2: rdata_d = cfg_q.knee1_len[23:16];
                `EHS_A_KNEE2_0: rdata_d = cfg_q.knee2_len[7:0];
                `EHS_A_KNEE2_1: rdata_d = cfg_q.knee2_len[15:8];
                `EHS_A_KNEE2_2: rdata_d = cfg_q.knee2_len[23:16];
                `EHS_A_SLOPES: rdata_d = {6'h00, cfg_q.slopes};
                `EHS_A_ODD0: rdata_d = cfg_q.odd_len[7:0];
                `EHS_A_ODD1: rdata_d = cfg_q.odd_len[15:8];
                `EHS_A_ODD2: rdata_d = cfg_q.odd_len[23:16];
                `EHS_A_OVH: rdata_d = cfg_q.ovh;
                `EHS_A_CLIP2: rdata_d = {1'b0, cfg_q.clip2};
                `EHS_A_CLIP3: rdata_d = {1'b0, cfg_q.clip3};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cfg_q.mono <= `EHS_RST_MONO;
            cfg_q.ext <= `EHS_RST_EXT;
            cfg_q.ilv <= `EHS_RST_ILV;
            cfg_q.even_len <= `EHS_RST_EXP;
            cfg_q.knee1_len <= `EHS_RST_KNEE;
            cfg_q.knee2_len <= `EHS_RST_KNEE;
            cfg_q.slopes <= `EHS_RST_SLOPES;
            cfg_q.odd_len <= `EHS_RST_EXP;
            cfg_q.clip2 <= `EHS_RST_CLIP;
            cfg_q.clip3 <= `EHS_RST_CLIP;
            cfg_q.ovh <= `EHS_RST_OVH;
            rdata_q <= 8'h00;
        end
        else if (ce_i)
        begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    // span lengths in hundredths of a 129-clock unit
    function automatic logic [31:0] ehs_units(input logic [7:0] ovh, input logic [23:0] len);
        return {24'h000000, ovh} * `EHS_OVH_NUM + {8'h00, len} * `EHS_UNIT_DEN;
    endfunction : ehs_units

    function automatic logic [31:0] ehs_sub(input logic [31:0] a, input logic [31:0] b);
        return (a > b) ? a - b : 32'h00000001;
    endfunction : ehs_sub

    logic [31:0] u_total, u_odd, u_k1, u_k2, u_main, u_ovh;
    logic pwl, three;
    assign pwl = (cfg_q.slopes >= 2'h2) && !cfg_q.ilv;
    assign three = (cfg_q.slopes == 2'h3);
    assign u_total = ehs_units(cfg_q.ovh, cfg_q.even_len);
    assign u_odd = ehs_units(cfg_q.ovh, cfg_q.odd_len);
    assign u_k1 = ehs_units(cfg_q.ovh, cfg_q.knee1_len);
    assign u_k2 = ehs_units(cfg_q.ovh, cfg_q.knee2_len);
    assign u_ovh = ehs_units(cfg_q.ovh, 24'h000000) | {31'h0, cfg_q.ovh == 8'h00};
    // knees sit at the end of the total span
    assign u_main = !pwl ? u_total
        : (three ? ehs_sub(ehs_sub(u_total, u_k1), u_k2) : ehs_sub(u_total, u_k1));

    // span timers: a for main and knees, b for odd rows
    logic start_a, start_b, done_a, done_b, busy_b;
    logic [31:0] units_a;

    ehs_span_timer u_timer_a (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .start_i(start_a),
        .units_i(units_a),
        .done_o(done_a),
        .busy_o()
    );

    ehs_span_timer u_timer_b (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .start_i(start_b),
        .units_i(u_odd),
        .done_o(done_b),
        .busy_o(busy_b)
    );

    // exposure sequencer
    ehs_state_t st_q, st_d;
    ehs_clip_t clip_q, clip_d;
    logic even_q, even_d, odd_q, odd_d, done_q, done_d, knee_q, knee_d;
    logic act_q, act_d, grp_q, grp_d, busy_q, busy_d;
    logic [5:0] lvl_q, lvl_d;

    always_comb
    begin
        st_d = st_q;
        clip_d = clip_q;
        even_d = even_q;
        odd_d = odd_q;
        knee_d = knee_q;
        done_d = 1'b0;
        start_a = 1'b0;
        start_b = 1'b0;
        units_a = u_main;
        if (done_b)
            odd_d = 1'b0;
        unique case (st_q)
            ST_IDLE:
            begin
                clip_d = CLIP_NONE;
                knee_d = 1'b0;
                if (!cfg_q.ext && fr_rise)
                begin
                    start_a = 1'b1;
                    start_b = cfg_q.ilv;
                    even_d = 1'b1;
                    odd_d = 1'b1;
                    st_d = ST_MAIN;
                end
                else if (cfg_q.ext && a_rise)
                begin
                    even_d = 1'b1;
                    odd_d = !cfg_q.ilv;
                    st_d = ST_EXT;
                end
            end
            ST_MAIN:
            begin
                if (done_a)
                begin
                    if (pwl)
                    begin
                        start_a = 1'b1;
                        units_a = u_k1;
                        clip_d = CLIP_TWO;
                        st_d = ST_KNEE1;
                    end
                    else if (cfg_q.ilv && busy_b)
                    begin
                        even_d = 1'b0;
                        st_d = ST_ODD;
                    end
                    else
                        st_d = ST_IDLE;
                end
            end
            ST_KNEE1:
            begin
                if (done_a)
                begin
                    if (three)
                    begin
                        start_a = 1'b1;
                        units_a = u_k2;
                        clip_d = CLIP_THREE;
                        st_d = ST_KNEE2;
                    end
                    else
                        st_d = ST_IDLE;
                end
            end
            ST_KNEE2:
            begin
                if (done_a)
                    st_d = ST_IDLE;
            end
            ST_ODD:
            begin
                if (!busy_b)
                    st_d = ST_IDLE;
            end
            ST_EXT:
            begin
                if (fr_rise)
                begin
                    start_a = 1'b1;
                    units_a = u_ovh;
                    st_d = ST_TAIL;
                end
                else if (b_rise && cfg_q.ilv)
                    odd_d = 1'b1;
                else if (b_rise && pwl && !knee_q)
                begin
                    clip_d = CLIP_TWO;
                    knee_d = 1'b1;
                end
                else if (b_rise && pwl && three)
                    clip_d = CLIP_THREE;
            end
            ST_TAIL:
            begin
                if (done_a)
                    st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
        if (st_q != ST_IDLE && st_d == ST_IDLE)
        begin
            even_d = 1'b0;
            odd_d = 1'b0;
            clip_d = CLIP_NONE;
            done_d = 1'b1;
        end
        // clip level only drives the pixels when its enable bit is set
        act_d = (clip_d == CLIP_TWO && cfg_q.clip2[`EHS_B_CLIP_EN])
            || (clip_d == CLIP_THREE && cfg_q.clip3[`EHS_B_CLIP_EN]);
        lvl_d = (clip_d == CLIP_THREE) ? cfg_q.clip3[5:0] : cfg_q.clip2[5:0];
        grp_d = cfg_q.ilv && !cfg_q.mono;
        busy_d = (st_d != ST_IDLE);
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q <= ST_IDLE;
            clip_q <= CLIP_NONE;
            even_q <= 1'b0;
            odd_q <= 1'b0;
            knee_q <= 1'b0;
            done_q <= 1'b0;
            act_q <= 1'b0;
            lvl_q <= 6'h00;
            grp_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
            clip_q <= clip_d;
            even_q <= even_d;
            odd_q <= odd_d;
            knee_q <= knee_d;
            done_q <= done_d;
            act_q <= act_d;
            lvl_q <= lvl_d;
            grp_q <= grp_d;
            busy_q <= busy_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign expose_even_o = even_q;
    assign expose_odd_o = odd_q;
    assign clip_active_o = act_q;
    assign clip_level_o = lvl_q;
    assign row_pair_group_o = grp_q;
    assign busy_o = busy_q;
    assign exposure_done_o = done_q;

    chk_sel_bit: assert property (ce_i && reg_req_i.wr && reg_req_i.addr == `EHS_A_EXPCTL
        |=> cfg_q.ilv == $past(reg_req_i.wdata[`EHS_B_ILV]))
        else $error("interleave bit not taken from write");
    chk_even_start: assert property (ce_i && st_q == ST_IDLE && !cfg_q.ext && fr_rise
        |=> expose_even_o && st_q == ST_MAIN)
        else $error("internal exposure did not start");
    chk_odd_end: assert property (ce_i && done_b |=> !expose_odd_o)
        else $error("odd rows still exposed after their span");
    chk_pin_map: assert property (ce_i && st_q == ST_EXT && cfg_q.ilv && b_rise && !fr_rise
        |=> expose_odd_o && expose_even_o)
        else $error("pin b did not start odd rows");
    chk_bayer_group: assert property (ce_i ##1 ce_i
        |-> row_pair_group_o == $past(cfg_q.ilv && !cfg_q.mono))
        else $error("row grouping does not follow sensor type");
    chk_knee_clip: assert property (ce_i && st_q == ST_MAIN && done_a && pwl
        |=> st_q == ST_KNEE1 && clip_level_o == $past(cfg_q.clip2[5:0]))
        else $error("first knee did not apply clip level two");
    chk_slope_one: assert property (ce_i && st_q == ST_MAIN && done_a && cfg_q.slopes <= 2'h1
        && !cfg_q.ilv |=> st_q == ST_IDLE && exposure_done_o)
        else $error("single slope exposure did not end with main span");
    chk_ext_tail: assert property (ce_i && st_q == ST_EXT && fr_rise
        |=> st_q == ST_TAIL && expose_even_o)
        else $error("frame request did not close external exposure");

    cov_internal: cover property (st_q == ST_MAIN ##1 st_q == ST_KNEE1);
    cov_three: cover property (st_q == ST_KNEE2 && clip_active_o);
    cov_external: cover property (st_q == ST_TAIL ##1 exposure_done_o);
    cov_odd: cover property (st_q == ST_ODD);

endmodule : ehs_hdr_sequencer

//--- ehs_regs.svh
// register offsets, field positions, reset values and timing figures of the hdr sequencer
`ifndef EHS_REGS_SVH
`define EHS_REGS_SVH

// register addresses
`define EHS_A_SENSOR 7'h27
`define EHS_A_EXPCTL 7'h29
`define EHS_A_EVEN0 7'h2A
`define EHS_A_EVEN1 7'h2B
`define EHS_A_EVEN2 7'h2C
`define EHS_A_KNEE1_0 7'h30
`define EHS_A_KNEE1_1 7'h31
`define EHS_A_KNEE1_2 7'h32
`define EHS_A_KNEE2_0 7'h33
`define EHS_A_KNEE2_1 7'h34
`define EHS_A_KNEE2_2 7'h35
`define EHS_A_SLOPES 7'h36
`define EHS_A_ODD0 7'h38
`define EHS_A_ODD1 7'h39
`define EHS_A_ODD2 7'h3A
`define EHS_A_OVH 7'h49
`define EHS_A_CLIP2 7'h59
`define EHS_A_CLIP3 7'h5A

// field positions
`define EHS_B_MONO 0
`define EHS_B_EXT 0
`define EHS_B_ILV 1
`define EHS_B_CLIP_EN 6

// reset values
`define EHS_RST_MONO 1'h1
`define EHS_RST_EXT 1'h0
`define EHS_RST_ILV 1'h0
`define EHS_RST_EXP 24'h000800
`define EHS_RST_KNEE 24'h000001
`define EHS_RST_SLOPES 2'h1
`define EHS_RST_CLIP 7'h60
`define EHS_RST_OVH 8'h0A

// duration = 129 clocks * (0.43 * overhead + field), kept in hundredths
`define EHS_CYC_MULT 32'h00000081
`define EHS_OVH_NUM 32'h0000002B
`define EHS_UNIT_DEN 32'h00000064

`endif

//--- ehs_pkg.sv
// types shared by the hdr exposure sequencer
package ehs_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } ehs_reg_req_t;

    typedef struct packed {
        logic mono;
        logic ext;
        logic ilv;
        logic [23:0] even_len;
        logic [23:0] knee1_len;
        logic [23:0] knee2_len;
        logic [1:0] slopes;
        logic [23:0] odd_len;
        logic [6:0] clip2;
        logic [6:0] clip3;
        logic [7:0] ovh;
    } ehs_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_MAIN = 3'b001,
        ST_KNEE1 = 3'b010,
        ST_KNEE2 = 3'b011,
        ST_EXT = 3'b100,
        ST_TAIL = 3'b101,
        ST_ODD = 3'b110
    } ehs_state_t;

    typedef enum logic [1:0] {
        CLIP_NONE = 2'b00,
        CLIP_TWO = 2'b01,
        CLIP_THREE = 2'b10
    } ehs_clip_t;

endpackage : ehs_pkg

//--- ehs_span_timer.sv
// timer that runs one exposure or knee span given in hundredths of 129-clock units
`timescale 1ns/1ps
`include "ehs_regs.svh"
module ehs_span_timer
    import ehs_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic [31:0] units_i,
    output logic done_o,
    output logic busy_o
);
    logic [39:0] acc_q, acc_d, tgt_q, tgt_d, nxt;
    logic busy_q, busy_d, done_q, done_d;

    always_comb
    begin
        acc_d = acc_q;
        tgt_d = tgt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        nxt = acc_q + {8'h00, `EHS_UNIT_DEN};
        if (start_i)
        begin
            // whole cycles, rounded up: ceil(129 * units / 100)
            acc_d = 40'h0000000000;
            tgt_d = {8'h00, units_i} * {8'h00, `EHS_CYC_MULT};
            busy_d = 1'b1;
        end
        else if (busy_q)
        begin
            if (nxt >= tgt_q)
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
            else
            begin
                acc_d = nxt;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            acc_q <= 40'h0000000000;
            tgt_q <= 40'h0000000000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (ce_i)
        begin
            acc_q <= acc_d;
            tgt_q <= tgt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign done_o = done_q;
    assign busy_o = busy_q;

    // helper: busy cycles of the current span
    logic [39:0] cyc_q;
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cyc_q <= 40'h0000000000;
        else if (ce_i)
            cyc_q <= start_i ? 40'h0000000000 : (busy_q ? cyc_q + 40'h0000000001 : cyc_q);
    end

    chk_span_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && done_q |-> cyc_q == (tgt_q + 40'h0000000063) / {8'h00, `EHS_UNIT_DEN})
        else $error("span length differs from 129 * units / 100");

endmodule : ehs_span_timer

//--- ehs_ctl_model.sv
// model of the controller driving the configuration port and the exposure pins
`timescale 1ns/1ps
module ehs_ctl_model
    import ehs_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output ehs_reg_req_t req_o,
    output logic pin_a_o,
    output logic pin_b_o,
    output logic frame_o
);
    initial
    begin
        req_o = '0;
        pin_a_o = 1'b0;
        pin_b_o = 1'b0;
        frame_o = 1'b0;
    end

    // one request per call, then an idle cycle with scrambled address and data
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        req_o = '{1'b1, 1'b0, a, d};
        @(negedge clk_i);
        req_o = '{1'b0, 1'b0, ~a, ~d};
        @(negedge clk_i);
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        req_o = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_i);
        req_o = '{1'b0, 1'b0, ~a, 8'hA5};
        d = rdata_i;
        @(negedge clk_i);
    endtask : rd

    // 0: exposure pin a, 1: exposure pin b, 2: frame request; rising edge marks time
    task automatic pulse(input int sel);
        pin_a_o = (sel == 0) ? 1'b1 : pin_a_o;
        pin_b_o = (sel == 1) ? 1'b1 : pin_b_o;
        frame_o = (sel == 2) ? 1'b1 : frame_o;
        repeat (4) @(negedge clk_i);
        pin_a_o = 1'b0;
        pin_b_o = 1'b0;
        frame_o = 1'b0;
    endtask : pulse
endmodule : ehs_ctl_model

//--- tb_ehs_hdr_sequencer.sv
// self-checking testbench of the hdr exposure sequencer
`timescale 1ns/1ps
module tb_ehs_hdr_sequencer
    import ehs_pkg::*;
;
    logic clk_i, resetn_i, ce_i, pa, pb, fr, ev, od, ca, rpg, busy, done;
    ehs_reg_req_t req;
    logic [7:0] rdata, d;
    logic [5:0] lvl;
    logic [63:0] seen;
    int err_total, checks, ne, no, n1;

    ehs_hdr_sequencer i_ehs_hdr_sequencer (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .reg_req_i(req), .reg_rdata_o(rdata), .exposure_pin_a_i(pa), .exposure_pin_b_i(pb),
        .frame_req_i(fr), .expose_even_o(ev), .expose_odd_o(od), .clip_active_o(ca),
        .clip_level_o(lvl), .row_pair_group_o(rpg), .busy_o(busy), .exposure_done_o(done));
    ehs_ctl_model i_ehs_ctl_model (.clk_i(clk_i), .rdata_i(rdata), .req_o(req), .pin_a_o(pa),
        .pin_b_o(pb), .frame_o(fr));

    // exposure cycle counters and clip levels seen while applied
    always @(posedge clk_i)
    begin
        ne <= ne + int'(ev);
        no <= no + int'(od);
        if (ca === 1'b1)
            seen[lvl] <= 1'b1;
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    task automatic w(input logic [6:0] a, input logic [7:0] v);
        i_ehs_ctl_model.wr(a, v);
    endtask : w

    // low address takes the low byte
    task automatic w24(input logic [6:0] a, input logic [23:0] v);
        w(a, v[7:0]);
        w(a + 7'h01, v[15:8]);
        w(a + 7'h02, v[23:16]);
    endtask : w24

    task automatic clr();
        ne = 0;
        no = 0;
        seen = '0;
    endtask : clr

    task automatic wdone();
        int k;
        k = 0;
        while (done !== 1'b1 && k < 3000)
        begin
            @(negedge clk_i);
            k++;
        end
        chk("done", int'(k < 3000), 1);
        @(negedge clk_i);
    endtask : wdone

    task automatic t_reset();
        logic [6:0] ad[19] = '{7'h27, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h30, 7'h31, 7'h32, 7'h33,
            7'h34, 7'h35, 7'h36, 7'h38, 7'h39, 7'h3A, 7'h49, 7'h59, 7'h5A, 7'h37};
        logic [7:0] ex[19] = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01,
            8'h00, 8'h00, 8'h01, 8'h00, 8'h08, 8'h00, 8'h0A, 8'h60, 8'h60, 8'h00};
        chk("busy", busy, 1'b0);
        for (int i = 0; i < 19; i++)
        begin
            i_ehs_ctl_model.rd(ad[i], d);
            chk("reset value", d, ex[i]);
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs();
        w24(7'h2A, 24'h123456);
        i_ehs_ctl_model.rd(7'h2A, d);
        chk("even low", d, 8'h56);
        i_ehs_ctl_model.rd(7'h2C, d);
        chk("even high", d, 8'h12);
        w(7'h59, 8'h7F);
        i_ehs_ctl_model.rd(7'h59, d);
        chk("clip two", d, 8'h7F);
        $display("test registers done");
    endtask : t_regs

    task automatic t_int();
        w(7'h49, 8'h00);
        w24(7'h2A, 24'h000001);
        clr();
        i_ehs_ctl_model.pulse(2);
        wdone();
        n1 = ne;
        chk("even span", int'(n1 >= 129 && n1 <= 131), 1);
        w(7'h49, 8'h01);
        clr();
        i_ehs_ctl_model.pulse(2);
        wdone();
        chk("overhead span", ne - n1, 56);
        w(7'h49, 8'h00);
        $display("test internal done");
    endtask : t_int

    task automatic t_ilv();
        w(7'h29, 8'h02);
        w(7'h27, 8'h00);
        chk("row pairs", rpg, 1'b1);
        w24(7'h38, 24'h000002);
        clr();
        i_ehs_ctl_model.pulse(2);
        wdone();
        chk("odd minus even", no - ne, 129);
        w(7'h27, 8'h01);
        chk("row pairs mono", rpg, 1'b0);
        $display("test interleave done");
    endtask : t_ilv

    task automatic t_pwl();
        w(7'h29, 8'h00);
        w(7'h36, 8'h03);
        w24(7'h2A, 24'h00000A);
        w(7'h59, 8'h45);
        w(7'h5A, 8'h4A);
        clr();
        i_ehs_ctl_model.pulse(2);
        wdone();
        chk("clip two seen", seen[5], 1'b1);
        chk("clip three seen", seen[10], 1'b1);
        chk("total span", int'(ne >= 1290 && ne <= 1296), 1);
        w(7'h36, 8'h02);
        w(7'h59, 8'h05);
        clr();
        i_ehs_ctl_model.pulse(2);
        wdone();
        chk("clip disabled", {31'h0, |seen}, 32'h0);
        $display("test piecewise done");
    endtask : t_pwl

    task automatic t_ext();
        w(7'h29, 8'h03);
        clr();
        i_ehs_ctl_model.pulse(0);
        repeat (6) @(negedge clk_i);
        i_ehs_ctl_model.pulse(1);
        repeat (16) @(negedge clk_i);
        i_ehs_ctl_model.pulse(2);
        wdone();
        chk("pin a minus pin b", ne - no, 10);
        chk("external span", int'(ne >= 30 && ne <= 36), 1);
        w(7'h29, 8'h01);
        w(7'h59, 8'h45);
        clr();
        i_ehs_ctl_model.pulse(0);
        repeat (6) @(negedge clk_i);
        i_ehs_ctl_model.pulse(1);
        repeat (6) @(negedge clk_i);
        i_ehs_ctl_model.pulse(2);
        wdone();
        chk("external clip", seen[5], 1'b1);
        $display("test external done");
    endtask : t_ext

    // clock enable low freezes span and registers; reset mid-run clears outputs and reloads reset values
    task automatic t_hold();
        w(7'h29, 8'h00);
        w(7'h36, 8'h01);
        w24(7'h2A, 24'h000001);
        clr();
        i_ehs_ctl_model.pulse(2);
        chk("busy running", busy, 1'b1);
        ce_i = 1'b0;
        w(7'h36, 8'h03);
        repeat (48) @(negedge clk_i);
        ce_i = 1'b1;
        wdone();
        chk("frozen span", ne, 180);
        i_ehs_ctl_model.rd(7'h36, d);
        chk("frozen write", d, 8'h01);
        i_ehs_ctl_model.pulse(2);
        resetn_i = 1'b0;
        @(negedge clk_i);
        chk("reset outputs", {ev, od, busy, done, ca, rpg}, 6'h00);
        resetn_i = 1'b1;
        i_ehs_ctl_model.rd(7'h2A, d);
        chk("reset even low", d, 8'h00);
        chk("reset idle", busy, 1'b0);
        $display("test hold done");
    endtask : t_hold

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial
    begin
        resetn_i = 1'b0;
        ce_i = 1'b1;
        err_total = 0;
        checks = 0;
        clr();
        repeat (20) @(negedge clk_i);
        resetn_i = 1'b1;
        t_reset();
        t_regs();
        t_int();
        t_ilv();
        t_pwl();
        t_ext();
        t_hold();
        stop_test();
    end

    // about eight times the expected run
    initial
    begin
        #3000000;
        err_total++;
        stop_test();
    end
endmodule : tb_ehs_hdr_sequencer
